// ===== core/pixel_readout_mode_control.sv
// Readout-mode control: context registers over AXI4-Lite, frame/line timing, pixel stream.
// Assumes a pixel array that returns arr_data combinationally for arr_row/arr_col.
// Functional notes
// - With zoom enabled, zoom code 00/01/10/11 gives 2x/4x/8x/16x magnification.
// - Context B single-converter bit clear runs full speed; set halves the pixel rate.
// - Context A has the same single-converter option and it resets to one.
// - Border enabled but not shown adds eight rows of vertical and eight pixels of horizontal blanking.
// - Border enabled and shown stretches frame-valid by eight rows and line-valid by eight pixels.
// - Oversize with the border shown puts a four-pixel border round the array, adding eight rows and columns.
// - Each context's column-skip enable picks skipped or normal readout, only for the selected context.
// - Column-skip code 00 gives 2x, 01 gives 4x, 10 and 11 give 8x.
// - Row-skip code 00 gives 2x and 01 gives 4x; the higher codes give 8x and 16x.
// - The context-select bit applies context A when 0 and context B when 1.
// - Column mirror reads from start plus size down to start plus one, else start upward.
// - Row mirror reads from start plus size down to start plus one, else start upward.
// - Dark-column bit reads 36 columns from index 4 when set, 20 when clear, all 40 in binning.
// - Zoom keeps the pixel rate, holds each pixel for the factor and adds factor-1 zero rows.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "readout_cfg.svh"
module pixel_readout_mode_control #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pixel array
   output logic [ADDR_W-1:0] arr_row,
   output logic [ADDR_W-1:0] arr_col,
   input wire logic [9:0] arr_data,
   output logic dark_rd,
   output logic [7:0] dark_col,
   // Pixel stream to output timing
   output logic pix_valid,
   output readout_pkg::pix_beat_s pix_beat,
   input wire logic pix_ready
);
   import readout_pkg::*;

   if (ADDR_W < 11 || ADDR_W > 16) begin : g_chk
      $error("ADDR_W must cover the array and stay within 16 bits");
   end

   logic [15:0] ctx_a_q, ctx_b_q, show_q, ctx_sel_q;
   logic [31:0] win_col_q, win_row_q, blank_q;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_got_q, w_got_q;
   logic [15:0] frame_cnt_q;
   read_mode_s cfg_q, cfg_live, cfg_use;
   scan_state_e st_q;
   logic vline_q, pace_q, last_row_q, ctx_q;
   logic [15:0] tcnt_q, hb_len, ndark;
   logic [11:0] vrow_q, vb_rows;
   logic [3:0] hold_q, zrem_q, zmax;
   logic pace_ok, adv, buf_ready, hb_phase, line_phase, hb_end, line_end, fs;
   logic col_load, col_step, row_load, row_step, col_last, row_last;
   logic hidden;
   pix_beat_s beat;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Write side: address and data taken in either order, answered once both are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         w_got_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctx_a_q <= `CTX_A_RST;
         ctx_b_q <= `CTX_B_RST;
         show_q <= `SHOW_RST;
         ctx_sel_q <= `CTX_SEL_RST;
         win_col_q <= `WIN_COL_RST;
         win_row_q <= `WIN_ROW_RST;
         blank_q <= `BLANK_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= `AXI_OKAY;
         unique case (aw_addr_q[11:2])
            `IDX_CTX_A: ctx_a_q <= 16'(merge({16'h0000, ctx_a_q}, w_data_q, w_strb_q & 4'h3));
            `IDX_CTX_B: ctx_b_q <= 16'(merge({16'h0000, ctx_b_q}, w_data_q, w_strb_q & 4'h3));
            `IDX_SHOW: show_q <= 16'(merge({16'h0000, show_q}, w_data_q, w_strb_q & 4'h3));
            `IDX_CTX_SEL: ctx_sel_q <= 16'(merge({16'h0000, ctx_sel_q}, w_data_q, w_strb_q & 4'h3));
            `IDX_WIN_COL: win_col_q <= merge(win_col_q, w_data_q, w_strb_q);
            `IDX_WIN_ROW: win_row_q <= merge(win_row_q, w_data_q, w_strb_q);
            `IDX_BLANK: blank_q <= merge(blank_q, w_data_q, w_strb_q);
            default: s_axi_bresp <= `AXI_SLVERR;
         endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read side: one read at a time, data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `AXI_OKAY;
         unique case (s_axi_araddr[11:2])
            `IDX_CTX_A: s_axi_rdata <= {16'h0000, ctx_a_q};
            `IDX_CTX_B: s_axi_rdata <= {16'h0000, ctx_b_q};
            `IDX_SHOW: s_axi_rdata <= {16'h0000, show_q};
            `IDX_CTX_SEL: s_axi_rdata <= {16'h0000, ctx_sel_q};
            `IDX_WIN_COL: s_axi_rdata <= win_col_q;
            `IDX_WIN_ROW: s_axi_rdata <= win_row_q;
            `IDX_BLANK: s_axi_rdata <= blank_q;
            `IDX_STATUS: s_axi_rdata <= {frame_cnt_q, ndark[7:0], 3'b000, ctx_q, st_q, 1'b0, st_q != ST_VBLANK};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end

   // Live decode of the selected context; shared fields always come from the context B word
   always_comb begin
      logic [15:0] rm;
      rm = ctx_sel_q[`CTX_SEL_BIT] ? ctx_b_q : ctx_a_q;
      cfg_live.zlog = ctx_b_q[`RM_ZOOM_EN] ? {1'b0, ctx_b_q[`RM_ZOOM_LO +: 2]} + 3'd1 : 3'd0;
      cfg_live.one_adc = rm[`RM_ONE_ADC];
      cfg_live.show = ctx_b_q[`RM_SHOW_BORDER];
      cfg_live.oversize = ctx_b_q[`RM_OVERSIZE];
      if (!rm[`RM_CSKIP_EN]) begin
         cfg_live.clog = 3'd0;
      end else if (rm[`RM_CSKIP_LO + 1]) begin
         cfg_live.clog = 3'd3;
      end else begin
         cfg_live.clog = {2'b00, rm[`RM_CSKIP_LO]} + 3'd1;
      end
      cfg_live.rlog = rm[`RM_RSKIP_EN] ? {1'b0, rm[`RM_RSKIP_LO +: 2]} + 3'd1 : 3'd0;
      cfg_live.mir_c = ctx_b_q[`RM_MIRROR_COL];
      cfg_live.mir_r = ctx_b_q[`RM_MIRROR_ROW];
      cfg_live.binning = rm[`RM_BINNING];
   end

   // Frame start uses the fresh settings in the same cycle they are latched
   assign cfg_use = fs ? cfg_live : cfg_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= '0;
         cfg_q.one_adc <= 1'(`CTX_A_RST >> `RM_ONE_ADC);
         ctx_q <= 1'b0;
         frame_cnt_q <= 16'h0000;
      end else if (fs) begin
         cfg_q <= cfg_live;
         ctx_q <= ctx_sel_q[`CTX_SEL_BIT];
         frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
   end

   // Single converter: the readout divider only lets every other cycle through
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pace_q <= 1'b0;
      end else begin
         pace_q <= !pace_q;
      end
   end

   assign pace_ok = !cfg_q.one_adc || pace_q;
   assign adv = pace_ok && buf_ready;

   assign hidden = cfg_q.oversize && !cfg_q.show;
   assign ndark = cfg_q.binning ? `DARK_N40 : (show_q[`SHOW_DARK36] ? `DARK_N36 : `DARK_N20);
   assign hb_len = ((blank_q[15:0] > ndark) ? blank_q[15:0] : ndark) + (hidden ? `BORDER_EXTRA : 16'h0000);
   assign vb_rows = ((blank_q[27:16] == 12'h000) ? 12'h001 : blank_q[27:16])
      + 12'(hidden ? `BORDER_EXTRA : 16'h0000);
   assign zmax = 4'((5'd1 << cfg_q.zlog) - 5'd1);

   assign hb_phase = (st_q == ST_HBLANK) || (st_q == ST_VBLANK && !vline_q);
   assign line_phase = !hb_phase;
   assign hb_end = hb_phase && (tcnt_q == hb_len - 16'h0001);
   assign line_end = line_phase && (hold_q == zmax) && col_last;
   assign fs = adv && st_q == ST_VBLANK && line_end && (vrow_q == vb_rows - 12'h001);
   assign col_load = adv && hb_end;
   assign col_step = adv && line_phase && (hold_q == zmax);
   assign row_load = fs;
   assign row_step = adv && st_q == ST_ACTIVE && line_end && !row_last;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_VBLANK;
         vline_q <= 1'b0;
         tcnt_q <= 16'h0000;
         vrow_q <= 12'h000;
         hold_q <= 4'h0;
         zrem_q <= 4'h0;
         last_row_q <= 1'b0;
      end else if (adv) begin
         if (hb_phase) begin
            tcnt_q <= hb_end ? 16'h0000 : tcnt_q + 16'h0001;
         end
         if (line_phase) begin
            hold_q <= (hold_q == zmax) ? 4'h0 : hold_q + 4'h1;
         end
         unique case (st_q)
            ST_VBLANK: begin
               if (hb_end) begin
                  vline_q <= 1'b1;
               end else if (line_end) begin
                  vline_q <= 1'b0;
                  if (fs) begin
                     vrow_q <= 12'h000;
                     st_q <= ST_HBLANK;
                  end else begin
                     vrow_q <= vrow_q + 12'h001;
                  end
               end
            end
            ST_HBLANK: begin
               if (hb_end) begin
                  st_q <= (zrem_q != 4'h0) ? ST_ZROW : ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (line_end) begin
                  last_row_q <= row_last;
                  zrem_q <= zmax;
                  st_q <= (zmax == 4'h0 && row_last) ? ST_VBLANK : ST_HBLANK;
               end
            end
            ST_ZROW: begin
               if (line_end) begin
                  zrem_q <= zrem_q - 4'h1;
                  st_q <= (zrem_q == 4'h1 && last_row_q) ? ST_VBLANK : ST_HBLANK;
               end
            end
         endcase
      end
   end

   // Dark columns are fetched at the head of each horizontal blank
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dark_rd <= 1'b0;
         dark_col <= 8'h00;
      end else if (adv) begin
         dark_rd <= hb_phase && (tcnt_q < ndark);
         dark_col <= 8'(`DARK_FIRST + tcnt_q);
      end
   end

   scan_counter #(.W(ADDR_W)) u_col (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(col_load),
      .step(col_step),
      .start(win_col_q[ADDR_W-1:0]),
      .size(win_col_q[16 +: ADDR_W]),
      .skip_log(cfg_use.clog),
      .border(cfg_use.oversize && cfg_use.show),
      .mirror(cfg_use.mir_c),
      .addr_q(arr_col),
      .last(col_last)
   );

   scan_counter #(.W(ADDR_W)) u_row (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(row_load),
      .step(row_step),
      .start(win_row_q[ADDR_W-1:0]),
      .size(win_row_q[16 +: ADDR_W]),
      .skip_log(cfg_use.rlog),
      .border(cfg_use.oversize && cfg_use.show),
      .mirror(cfg_use.mir_r),
      .addr_q(arr_row),
      .last(row_last)
   );

   // One beat per pixel clock; zoom blank rows carry line-valid with zero data
   always_comb begin
      beat.fv = st_q != ST_VBLANK;
      beat.lv = st_q == ST_ACTIVE || st_q == ST_ZROW;
      beat.data = (st_q == ST_ACTIVE) ? arr_data : 10'h000;
   end

   // The whole engine stalls while the buffer is full, so no beat is lost
   pix_buffer #(.W($bits(pix_beat_s))) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(pace_ok),
      .in_data(beat),
      .in_ready(buf_ready),
      .out_valid(pix_valid),
      .out_data(pix_beat),
      .out_ready(pix_ready)
   );
endmodule // pixel_readout_mode_control

// ===== core/readout_cfg.svh
// Register indices, field positions, reset values and fixed counts for readout-mode control.
// Assumes byte address = register index * 4 on a 32-bit AXI4-Lite bus.
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH
`define IDX_CTX_B 10'h020
`define IDX_CTX_A 10'h021
`define IDX_SHOW 10'h022
`define IDX_CTX_SEL 10'h0f2
`define IDX_WIN_COL 10'h040
`define IDX_WIN_ROW 10'h041
`define IDX_BLANK 10'h042
`define IDX_STATUS 10'h043
`define RM_BINNING 15
`define RM_ZOOM_EN 13
`define RM_ZOOM_LO 11
`define RM_ONE_ADC 10
`define RM_SHOW_BORDER 9
`define RM_OVERSIZE 8
`define RM_CSKIP_EN 7
`define RM_CSKIP_LO 5
`define RM_RSKIP_EN 4
`define RM_RSKIP_LO 2
`define RM_MIRROR_COL 1
`define RM_MIRROR_ROW 0
`define SHOW_DARK36 10
`define CTX_SEL_BIT 3
`define CTX_A_RST 16'h0490
`define CTX_B_RST 16'h0000
`define SHOW_RST 16'h0107
`define CTX_SEL_RST 16'h0000
`define WIN_COL_RST 32'h0640_0000
`define WIN_ROW_RST 32'h04b0_0000
`define BLANK_RST 32'h0008_0040
`define BORDER_PIX 16'h0004
`define BORDER_EXTRA 16'h0008
`define DARK_FIRST 16'h0004
`define DARK_N20 16'h0014
`define DARK_N36 16'h0024
`define DARK_N40 16'h0028
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// ===== core/readout_pkg.sv
// Types shared by the readout-mode control block.
// Assumes readout_cfg.svh supplies the numeric constants.
package readout_pkg;
   typedef enum logic [1:0] {
      ST_VBLANK = 2'b00,
      ST_HBLANK = 2'b01,
      ST_ACTIVE = 2'b11,
      ST_ZROW = 2'b10
   } scan_state_e;

   typedef struct packed {
      logic fv;
      logic lv;
      logic [9:0] data;
   } pix_beat_s;

   typedef struct packed {
      logic [2:0] zlog;
      logic one_adc;
      logic show;
      logic oversize;
      logic [2:0] clog;
      logic [2:0] rlog;
      logic mir_c;
      logic mir_r;
      logic binning;
   } read_mode_s;
endpackage

// ===== core/pix_buffer.sv
// Two-entry buffer with valid/ready on both sides; output comes from the head flop.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module pix_buffer #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic [W-1:0] spare_q;
   logic spare_v_q;
   logic push;
   logic pop;

   if (W < 1) begin : g_chk
      $error("pix_buffer width must be positive");
   end

   // Ready only while the spare slot is free, so a stall never drops a word
   assign in_ready = !spare_v_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
         spare_v_q <= 1'b0;
         spare_q <= '0;
      end else if (!out_valid || pop) begin
         if (spare_v_q) begin
            out_data <= spare_q;
            out_valid <= 1'b1;
            spare_v_q <= 1'b0;
         end else begin
            out_data <= in_data;
            out_valid <= push;
         end
      end else if (push) begin
         spare_q <= in_data;
         spare_v_q <= 1'b1;
      end
   end
endmodule // pix_buffer

// ===== core/scan_counter.sv
// Address walker for one array axis: window, border, skip factor and direction.
// Assumes start and size are settled whenever load is pulsed.
`timescale 1ns/10ps
`include "readout_cfg.svh"
module scan_counter #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic load,
   input wire logic step,
   input wire logic [W-1:0] start,
   input wire logic [W-1:0] size,
   input wire logic [2:0] skip_log,
   input wire logic border,
   input wire logic mirror,
   // Position
   output logic [W-1:0] addr_q,
   output logic last
);
   logic [W-1:0] left_q;
   logic [W-1:0] ext;
   logic [W-1:0] span;
   logic [W-1:0] count;
   logic [W-1:0] stride;

   if (W < 8 || W > 16) begin : g_chk
      $error("scan_counter width out of range");
   end

   assign ext = border ? W'(`BORDER_PIX) : '0;
   assign span = size + ext + ext;
   assign count = ((span >> skip_log) == '0) ? W'(1) : (span >> skip_log);
   assign stride = W'(1) << skip_log;
   assign last = (left_q == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_q <= '0;
         left_q <= '0;
      end else if (load) begin
         addr_q <= mirror ? start + size + ext : start - ext;
         left_q <= count - W'(1);
      end else if (step && !last) begin
         addr_q <= mirror ? addr_q - stride : addr_q + stride;
         left_q <= left_q - W'(1);
      end
   end
endmodule // scan_counter

// ===== tb/readout_chk.sv
// Port checker for the readout-mode control block.
// Assumes it is bound onto pixel_readout_mode_control.
`timescale 1ns/10ps
module readout_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Stream and dark columns
   input wire logic pix_valid,
   input wire readout_pkg::pix_beat_s pix_beat,
   input wire logic pix_ready,
   input wire logic dark_rd,
   input wire logic [7:0] dark_col
);
   import readout_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_after;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write response late");
   property p_b_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_after;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_after: assert property (p_r_after) else $error("read data late");
   property p_r_err;
      s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_r_err: assert property (p_r_err) else $error("bad read error answer");
   property p_pix_hold;
      pix_valid && !pix_ready |=> pix_valid && $stable(pix_beat);
   endproperty
   a_pix_hold: assert property (p_pix_hold) else $error("stalled beat changed");
   property p_lv_fv;
      pix_valid && pix_beat.lv |-> pix_beat.fv;
   endproperty
   a_lv_fv: assert property (p_lv_fv) else $error("line valid outside frame");
   property p_dark_start;
      $rose(dark_rd) |-> dark_col == 8'h04;
   endproperty
   a_dark_start: assert property (p_dark_start) else $error("dark run bad start");
   property p_dark_top;
      dark_rd |-> dark_col < 8'h2c;
   endproperty
   a_dark_top: assert property (p_dark_top) else $error("dark index too high");
endmodule // readout_chk
bind pixel_readout_mode_control readout_chk chk_i (.*);

// ===== tb/pix_sink.sv
// Host-side pixel sink; the bench watches the beats itself.
// Assumes one clock; stalls three clocks in eight to fill the buffer.
`timescale 1ns/10ps
module pix_sink (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Stream
   output logic pix_ready
);
   logic [2:0] cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 3'h0;
         pix_ready <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
         pix_ready <= (cnt_q < 3'h5);
      end
   end
endmodule // pix_sink

// ===== tb/testbench.sv
// Bench for readout-mode control: register tasks and frame capture.
// Assumes a 250 MHz clock and a small window written after reset.
`timescale 1ns/10ps
module testbench;
   import readout_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, pix_valid, pix_ready, dark_rd;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, arr_row, arr_col;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [9:0] arr_data;
   logic [7:0] dark_col;
   pix_beat_s pix_beat;
   int n_mismatch = 0, samples_checked = 0, ln, bt, zr, hb, dk, bb, f, cl, r;
   logic [9:0] fl[$];
   assign arr_data = {arr_row[4:0], arr_col[4:0]};
   always #2 aclk = ~aclk;
   pixel_readout_mode_control #(.ADDR_W(12)) uut (.*);
   pix_sink sink (.*);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      logic aw;
      logic w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   // Counts one whole frame; phases: wait blank, wait frame, inside, done
   task automatic cap;
      int ph;
      logic lv0;
      logic hs;
      logic dr0;
      logic [7:0] dc0;
      ph = 0;
      lv0 = 0;
      dr0 = 0;
      dc0 = 8'h00;
      {ln, bt, zr, hb, dk, bb} = '0;
      fl = {};
      while (ph < 3) begin
         @(posedge aclk);
         hs = pix_valid && pix_ready;
         if (hs && ph == 2 && !pix_beat.fv) ph = 3;
         if (hs && ph == 0 && !pix_beat.fv) ph = 1;
         if (hs && ph == 1 && pix_beat.fv) ph = 2;
         if (hs && ph == 2) begin
            if (pix_beat.lv) begin
               ln += !lv0;
               bt++;
               zr += (pix_beat.data == 10'h0);
               if (ln == 1) fl.push_back(pix_beat.data);
            end else begin
               hb++;
            end
            lv0 = pix_beat.lv;
         end
         // Dark runs lead the beats through the buffer, so count each once as it ends
         if (ph == 2 && dr0 && !dark_rd) dk += dc0 - 8'h03;
         bb += (ph == 2);
         dr0 = dark_rd;
         dc0 = dark_col;
      end
   endtask
   // Written in vertical blank, so the next frame carries the new setting
   task automatic run(input logic [15:0] v);
      wr(12'h080, {16'h0, v});
      cap();
   endtask
   task automatic final_report;
      $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      wr(12'h100, 32'h0010_0010);
      wr(12'h104, 32'h0010_0020);
      wr(12'h108, 32'h0001_0018);
      rd(12'h084, 32'h0490);
      rd(12'h080, 32'h0);
      rd(12'h088, 32'h0107);
      rd(12'h3c8, 32'h0);
      rd(12'hffc, 32'h0, 2'b10);
      wr(12'h10c, 32'h0, 2'b10);
      cap();
      chk("lines", 8, ln);
      chk("pix1", 32'h012, fl[1]);
      chk("halfrate", 1, 2 * (bt + hb) <= bb + 16);
      chk("dark", 160, dk);
      wr(12'h3c8, 32'h8);
      run(16'h0000);
      chk("lines", 16, ln);
      chk("pix1", 32'h011, fl[1]);
      chk("halfrate", 0, 2 * (bt + hb) <= bb + 16);
      run(16'h0003);
      chk("pix0", 32'h200, fl[0]);
      chk("pix1", 32'h21f, fl[1]);
      rd(12'h080, 32'h3);
      run(16'h0400);
      chk("halfrate", 1, 2 * (bt + hb) <= bb + 16);
      run(16'h0100);
      chk("lines", 16, ln);
      chk("hblank", 512, hb);
      run(16'h0300);
      chk("lines", 24, ln);
      chk("beats", 576, bt);
      chk("pix0", 32'h38c, fl[0]);
      for (int k = 0; k < 4; k++) begin
         f = 2 << k;
         r = 16 >> (k + 1);
         cl = (k == 3) ? 3 : k + 1;
         run(16'(32'h2090 | (k << 11) | (k << 5) | (k << 2)));
         chk("lines", r * f, ln);
         chk("beats", r * f * (16 >> cl) * f, bt);
         chk("zeros", r * (f - 1) * (16 >> cl) * f, zr);
         chk("pixlast", 32'h010, fl[f-1]);
         chk("pixnext", 32'h010 + (1 << cl), fl[f]);
      end
      wr(12'h088, 32'h0507);
      run(16'h0000);
      chk("dark", 576, dk);
      run(16'h8000);
      chk("darkline", 40, dk / ln);
      final_report();
   end
endmodule // testbench
